// >>> include/cyclic_msg_pkg.sv
// shared constants and types for the fieldbus cyclic message port
package cyclic_msg_pkg;
    localparam int WORD_W = 16;
    localparam int IMG_WORDS = 64;
    localparam int RESP_WORDS = 63;
    localparam int STAT_WORDS = 32;
    localparam int NUM_AXES = 8;
    // command block word indices
    localparam logic [5:0] SYNC_IDX = 6'h00;
    localparam logic [5:0] WR_ADDR_IDX = 6'h3b;
    localparam logic [5:0] WR_LEN_IDX = 6'h3c;
    localparam logic [5:0] RD_ADDR_IDX = 6'h3d;
    localparam logic [5:0] RD_LEN_IDX = 6'h3e;
    localparam logic [5:0] HS_IDX = 6'h3f;
    localparam int RD_FLAG_BIT = 15;
    localparam int WR_FLAG_BIT = 14;
    localparam logic [15:0] WR_LEN_MAX = 16'h003b;
    localparam logic [15:0] RD_LEN_MAX = 16'h003f;
    localparam logic [5:0] STAT_LAST = 6'h1f;
    localparam logic [5:0] AXIS_LAST = 6'h07;
    localparam logic [5:0] AXIS_STEP = 6'h01;
    // input image layout: response words, handshake word, status block
    localparam logic [6:0] IN_HS_IDX = 7'h3f;
    localparam logic [6:0] IN_STAT_BASE = 7'h40;
    localparam logic [6:0] IN_LAST = 7'h5f;
    // device register space landmarks
    localparam logic [15:0] RO_END = 16'h0050;
    localparam logic [15:0] MAP_BASE = 16'h0a00;
    localparam logic [15:0] MAP_LAST = 16'h0a1f;
    // status block refresh timing
    localparam int CLK_MHZ = 10;
    localparam int IDLE_REFRESH_US = 2000;
    localparam int BUSY_REFRESH_US = 6000;
    localparam int IDLE_REFRESH_CYC = IDLE_REFRESH_US * CLK_MHZ;
    localparam int BUSY_REFRESH_CYC = BUSY_REFRESH_US * CLK_MHZ;
    localparam int TIMER_W = 17;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WR = 3'b001,
        ST_RD = 3'b010,
        ST_DRAIN = 3'b011,
        ST_STAT = 3'b100,
        ST_SCAN = 3'b101
    } engine_state_e;
endpackage : cyclic_msg_pkg

// >>> rtl/cmd_image.sv
// host output image store: one write port, two asynchronous read ports
`timescale 1ns/1ns
`default_nettype none
module cmd_image (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [5:0] wr_idx,
    input wire logic [15:0] wr_data,
    input wire logic [5:0] rd_idx_a,
    output logic [15:0] rd_data_a,
    input wire logic [5:0] rd_idx_b,
    output logic [15:0] rd_data_b
);
    logic [15:0] mem_r [cyclic_msg_pkg::IMG_WORDS];

    // cleared at reset so a scan never compares unknown words
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < cyclic_msg_pkg::IMG_WORDS; i++)
                mem_r[i] <= 16'h0000;
        end
        else if (wr_en)
            mem_r[wr_idx] <= wr_data;
    end

    assign rd_data_a = mem_r[rd_idx_a];
    assign rd_data_b = mem_r[rd_idx_b];
endmodule : cmd_image
`default_nettype wire

// >>> rtl/refresh_timer.sv
// status block refresh divider, slow period while a request is busy
`timescale 1ns/1ns
`default_nettype none
module refresh_timer #(
    parameter int IDLE_CYC = cyclic_msg_pkg::IDLE_REFRESH_CYC,
    parameter int BUSY_CYC = cyclic_msg_pkg::BUSY_REFRESH_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic busy,
    output logic tick
);
    localparam int TW = cyclic_msg_pkg::TIMER_W;
    logic [TW-1:0] count_r;
    logic [TW-1:0] limit;

    // limit follows busy live, so a request stretches the running period
    assign limit = busy ? TW'(BUSY_CYC - 1) : TW'(IDLE_CYC - 1);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            count_r <= '0;
            tick <= 1'b0;
        end
        else if (count_r >= limit)
        begin
            count_r <= '0;
            tick <= 1'b1;
        end
        else
        begin
            count_r <= count_r + TW'(1);
            tick <= 1'b0;
        end
    end
endmodule : refresh_timer
`default_nettype wire

// >>> rtl/fieldbus_cyclic_message_port.sv
// fieldbus cyclic image port: cyclic direct commands and block transfer messaging
// How it works
// - cyclic mode: each axis has command and data words, processed on sync word change in the sync variant, on every pass otherwise
// - expansion module's two extra output words after the axes are never read
// - sync variant: sync word at 0, axis n command at 2n+1, data at 2n+2
// - cyclic mode drops a command equal to the axis's previous one
// - block mode: every request toggle is processed, even if identical
// - status block refreshed every 2ms idle, 6ms while a request runs
// - each status word is read from an address held in a 32-entry map
// - host command block is 64 words, last word carries the request flags
// - response words change only as result of a triggered read
// - write data words 0-58, address word 59, length 0-59 word 60
// - read address word 61, length 0-63 word 62, data back in 0-62
// - command word 63: bit 15 read request, bit 14 write request
// - response word 63: bit 15 read acknowledge, bit 14 write acknowledge
// - read: fill read data, then make read acknowledge equal request
// - write: take all data, then make write acknowledge equal request
// - simultaneous requests: write runs first, read starts after it
// - simultaneous requests: both acknowledges change in the same cycle
// - write into spline area sets wait flag 7
// - sync variant: after the scan the sync word is echoed to the input image
// - writes to the read-only axis status addresses are dropped
// - status map lives at 2560-2591, readable and writable by block requests
`timescale 1ns/1ns
`default_nettype none
module fieldbus_cyclic_message_port #(
    parameter int IDLE_REFRESH_CYC = cyclic_msg_pkg::IDLE_REFRESH_CYC,
    parameter int BUSY_REFRESH_CYC = cyclic_msg_pkg::BUSY_REFRESH_CYC,
    parameter logic [15:0] SPLINE_FIRST = 16'h4000,
    parameter logic [15:0] SPLINE_LAST = 16'h7fff
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic block_mode,
    input wire logic sync_variant,
    input wire logic out_we,
    input wire logic [5:0] out_addr,
    input wire logic [15:0] out_data,
    input wire logic [6:0] in_addr,
    output logic [15:0] in_data_r,
    output logic reg_wr_en_r,
    output logic reg_rd_en_r,
    output logic [15:0] reg_addr_r,
    output logic [15:0] reg_wdata_r,
    input wire logic [15:0] reg_rdata,
    output logic axis_cmd_valid_r,
    output logic [2:0] axis_idx_r,
    output logic [15:0] axis_cmd_r,
    output logic [15:0] axis_data_r,
    output logic wait_bit7_r,
    input wire logic wait_bit7_clr
);
    cyclic_msg_pkg::engine_state_e state_r;
    logic [5:0] cnt_r;
    logic [15:0] wr_base_r, wr_len_r, rd_base_r, rd_len_r, sync_word_r;
    logic rd_req_r, wr_req_r, rd_ack_r, wr_ack_r, rd_tgt_r, wr_tgt_r;
    logic both_r, op_stat_r, tick_pend_r;
    logic [15:0] last_sync_r, sync_echo_r;
    logic p1_v_r, p1_map_r, p1_stat_r, p2_v_r, p2_map_r, p2_stat_r;
    logic [5:0] p1_idx_r, p2_idx_r;
    logic [15:0] p1_mapval_r, p2_mapval_r;
    logic [15:0] map_mem_r [cyclic_msg_pkg::STAT_WORDS];
    logic [15:0] resp_mem_r [cyclic_msg_pkg::RESP_WORDS];
    logic [15:0] stat_mem_r [cyclic_msg_pkg::STAT_WORDS];
    logic [15:0] last_cmd_r [cyclic_msg_pkg::NUM_AXES];
    logic [15:0] wr_len_cl, rd_len_cl, cur_addr, map_off;
    logic issue_wr, issue_rd, map_hit, ro_hit, spline_hit;
    logic pend_wr, pend_rd, busy, scan_go, stat_start, refresh_tick;
    logic [5:0] idx_a, idx_b, scan_base;
    logic [15:0] rd_data_a, rd_data_b;
    logic [6:0] stat_in_off;

    // whole host output image, written word by word as frames arrive
    cmd_image u_cmd_image (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_en(out_we),
        .wr_idx(out_addr),
        .wr_data(out_data),
        .rd_idx_a(idx_a),
        .rd_data_a(rd_data_a),
        .rd_idx_b(idx_b),
        .rd_data_b(rd_data_b)
    );

    refresh_timer #(
        .IDLE_CYC(IDLE_REFRESH_CYC),
        .BUSY_CYC(BUSY_REFRESH_CYC)
    ) u_refresh_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .busy(busy),
        .tick(refresh_tick)
    );

    // snoop the control words so the engine needs no extra read ports
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wr_base_r <= 16'h0000;
            wr_len_r <= 16'h0000;
            rd_base_r <= 16'h0000;
            rd_len_r <= 16'h0000;
            sync_word_r <= 16'h0000;
            rd_req_r <= 1'b0;
            wr_req_r <= 1'b0;
        end
        else if (out_we)
        begin
            case (out_addr)
                cyclic_msg_pkg::SYNC_IDX: sync_word_r <= out_data;
                cyclic_msg_pkg::WR_ADDR_IDX: wr_base_r <= out_data;
                cyclic_msg_pkg::WR_LEN_IDX: wr_len_r <= out_data;
                cyclic_msg_pkg::RD_ADDR_IDX: rd_base_r <= out_data;
                cyclic_msg_pkg::RD_LEN_IDX: rd_len_r <= out_data;
                cyclic_msg_pkg::HS_IDX:
                begin
                    rd_req_r <= out_data[cyclic_msg_pkg::RD_FLAG_BIT];
                    wr_req_r <= out_data[cyclic_msg_pkg::WR_FLAG_BIT];
                end
                default: ;
            endcase
        end
    end

    // address generation and decode for the current engine step
    always_comb
    begin
        wr_len_cl = (wr_len_r > cyclic_msg_pkg::WR_LEN_MAX) ? cyclic_msg_pkg::WR_LEN_MAX : wr_len_r;
        rd_len_cl = (rd_len_r > cyclic_msg_pkg::RD_LEN_MAX) ? cyclic_msg_pkg::RD_LEN_MAX : rd_len_r;
        case (state_r)
            cyclic_msg_pkg::ST_STAT: cur_addr = map_mem_r[cnt_r[4:0]];
            cyclic_msg_pkg::ST_WR: cur_addr = wr_base_r + {10'h000, cnt_r};
            default: cur_addr = rd_base_r + {10'h000, cnt_r};
        endcase
        issue_wr = (state_r == cyclic_msg_pkg::ST_WR) && ({10'h000, cnt_r} < wr_len_cl);
        issue_rd = ((state_r == cyclic_msg_pkg::ST_RD) && ({10'h000, cnt_r} < rd_len_cl))
            || (state_r == cyclic_msg_pkg::ST_STAT);
        map_hit = (cur_addr >= cyclic_msg_pkg::MAP_BASE) && (cur_addr <= cyclic_msg_pkg::MAP_LAST);
        map_off = cur_addr - cyclic_msg_pkg::MAP_BASE;
        ro_hit = cur_addr < cyclic_msg_pkg::RO_END;
        spline_hit = (cur_addr >= SPLINE_FIRST) && (cur_addr <= SPLINE_LAST);
        pend_wr = wr_req_r != wr_ack_r;
        pend_rd = rd_req_r != rd_ack_r;
        busy = (state_r == cyclic_msg_pkg::ST_WR) || (state_r == cyclic_msg_pkg::ST_RD)
            || ((state_r == cyclic_msg_pkg::ST_DRAIN) && !op_stat_r);
        scan_base = sync_variant ? cyclic_msg_pkg::AXIS_STEP : 6'h00;
        idx_b = scan_base + {2'b00, cnt_r[2:0], 1'b0};
        idx_a = (state_r == cyclic_msg_pkg::ST_SCAN) ? idx_b + cyclic_msg_pkg::AXIS_STEP : cnt_r;
        // no sync word: scan repeats, duplicate filter keeps it quiet
        scan_go = sync_variant ? (sync_word_r != last_sync_r) : 1'b1;
        stat_start = (state_r == cyclic_msg_pkg::ST_IDLE) && block_mode && !pend_wr && !pend_rd && tick_pend_r;
    end

    // a refresh tick is remembered until the engine is free to serve it
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            tick_pend_r <= 1'b0;
        else
        begin
            if (stat_start)
                tick_pend_r <= 1'b0;
            if (refresh_tick)
                tick_pend_r <= 1'b1;
        end
    end

    // engine: write, then read, then acknowledge; status pass fills idle gaps
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_r <= cyclic_msg_pkg::ST_IDLE;
            cnt_r <= 6'h00;
            rd_ack_r <= 1'b0;
            wr_ack_r <= 1'b0;
            rd_tgt_r <= 1'b0;
            wr_tgt_r <= 1'b0;
            both_r <= 1'b0;
            op_stat_r <= 1'b0;
            last_sync_r <= 16'h0000;
        end
        else
        begin
            case (state_r)
                cyclic_msg_pkg::ST_IDLE:
                begin
                    cnt_r <= 6'h00;
                    if (block_mode)
                    begin
                        // no compare with the last request: every toggle runs
                        if (pend_wr)
                        begin
                            state_r <= cyclic_msg_pkg::ST_WR;
                            both_r <= pend_rd;
                            wr_tgt_r <= wr_req_r;
                            rd_tgt_r <= rd_req_r;
                        end
                        else if (pend_rd)
                        begin
                            state_r <= cyclic_msg_pkg::ST_RD;
                            both_r <= 1'b0;
                            rd_tgt_r <= rd_req_r;
                        end
                        else if (tick_pend_r)
                        begin
                            state_r <= cyclic_msg_pkg::ST_STAT;
                            op_stat_r <= 1'b1;
                        end
                    end
                    else if (scan_go)
                    begin
                        state_r <= cyclic_msg_pkg::ST_SCAN;
                        last_sync_r <= sync_word_r;
                    end
                end
                cyclic_msg_pkg::ST_WR:
                begin
                    if (issue_wr)
                        cnt_r <= cnt_r + 6'h01;
                    else
                    begin
                        cnt_r <= 6'h00;
                        if (both_r)
                            state_r <= cyclic_msg_pkg::ST_RD;
                        else
                        begin
                            wr_ack_r <= wr_tgt_r;
                            state_r <= cyclic_msg_pkg::ST_IDLE;
                        end
                    end
                end
                cyclic_msg_pkg::ST_RD:
                begin
                    if (issue_rd)
                        cnt_r <= cnt_r + 6'h01;
                    else
                        state_r <= cyclic_msg_pkg::ST_DRAIN;
                end
                cyclic_msg_pkg::ST_STAT:
                begin
                    if (cnt_r == cyclic_msg_pkg::STAT_LAST)
                        state_r <= cyclic_msg_pkg::ST_DRAIN;
                    else
                        cnt_r <= cnt_r + 6'h01;
                end
                cyclic_msg_pkg::ST_DRAIN:
                begin
                    // acknowledge only once the last read word has landed
                    if (!p1_v_r && !p2_v_r)
                    begin
                        state_r <= cyclic_msg_pkg::ST_IDLE;
                        if (!op_stat_r)
                        begin
                            rd_ack_r <= rd_tgt_r;
                            if (both_r)
                                wr_ack_r <= wr_tgt_r;
                        end
                        op_stat_r <= 1'b0;
                        both_r <= 1'b0;
                    end
                end
                cyclic_msg_pkg::ST_SCAN:
                begin
                    // axis words only: reserved expansion words are never touched
                    if (cnt_r == cyclic_msg_pkg::AXIS_LAST)
                        state_r <= cyclic_msg_pkg::ST_IDLE;
                    else
                        cnt_r <= cnt_r + 6'h01;
                end
                default: state_r <= cyclic_msg_pkg::ST_IDLE;
            endcase
        end
    end

    // register space strobes, one cycle each
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            reg_wr_en_r <= 1'b0;
            reg_rd_en_r <= 1'b0;
            reg_addr_r <= 16'h0000;
            reg_wdata_r <= 16'h0000;
        end
        else
        begin
            reg_wr_en_r <= issue_wr && !map_hit && !ro_hit;
            reg_rd_en_r <= issue_rd && !map_hit;
            reg_addr_r <= cur_addr;
            reg_wdata_r <= rd_data_a;
        end
    end

    // read return pipeline: data comes back the cycle after the strobe
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            p1_v_r <= 1'b0;
            p1_map_r <= 1'b0;
            p1_stat_r <= 1'b0;
            p1_idx_r <= 6'h00;
            p1_mapval_r <= 16'h0000;
            p2_v_r <= 1'b0;
            p2_map_r <= 1'b0;
            p2_stat_r <= 1'b0;
            p2_idx_r <= 6'h00;
            p2_mapval_r <= 16'h0000;
        end
        else
        begin
            p1_v_r <= issue_rd;
            p1_map_r <= map_hit;
            p1_stat_r <= state_r == cyclic_msg_pkg::ST_STAT;
            p1_idx_r <= cnt_r;
            p1_mapval_r <= map_mem_r[map_off[4:0]];
            p2_v_r <= p1_v_r;
            p2_map_r <= p1_map_r;
            p2_stat_r <= p1_stat_r;
            p2_idx_r <= p1_idx_r;
            p2_mapval_r <= p1_mapval_r;
        end
    end

    // response and status words only move when a read lands
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < cyclic_msg_pkg::RESP_WORDS; i++)
                resp_mem_r[i] <= 16'h0000;
            for (int i = 0; i < cyclic_msg_pkg::STAT_WORDS; i++)
                stat_mem_r[i] <= 16'h0000;
        end
        else if (p2_v_r)
        begin
            if (p2_stat_r)
                stat_mem_r[p2_idx_r[4:0]] <= p2_map_r ? p2_mapval_r : reg_rdata;
            else
                resp_mem_r[p2_idx_r] <= p2_map_r ? p2_mapval_r : reg_rdata;
        end
    end

    // status map table, written through block writes
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < cyclic_msg_pkg::STAT_WORDS; i++)
                map_mem_r[i] <= 16'h0000;
        end
        else if (issue_wr && map_hit)
            map_mem_r[map_off[4:0]] <= rd_data_a;
    end

    // spline download flag; a new download beats a clear in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            wait_bit7_r <= 1'b0;
        else
        begin
            if (wait_bit7_clr)
                wait_bit7_r <= 1'b0;
            if (issue_wr && spline_hit)
                wait_bit7_r <= 1'b1;
        end
    end

    // cyclic scan: forward only changed commands, then echo the sync word
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            axis_cmd_valid_r <= 1'b0;
            axis_idx_r <= 3'h0;
            axis_cmd_r <= 16'h0000;
            axis_data_r <= 16'h0000;
            sync_echo_r <= 16'h0000;
            for (int i = 0; i < cyclic_msg_pkg::NUM_AXES; i++)
                last_cmd_r[i] <= 16'h0000;
        end
        else
        begin
            axis_cmd_valid_r <= 1'b0;
            if (state_r == cyclic_msg_pkg::ST_SCAN)
            begin
                if (rd_data_b != last_cmd_r[cnt_r[2:0]])
                begin
                    axis_cmd_valid_r <= 1'b1;
                    axis_idx_r <= cnt_r[2:0];
                    axis_cmd_r <= rd_data_b;
                    axis_data_r <= rd_data_a;
                    last_cmd_r[cnt_r[2:0]] <= rd_data_b;
                end
                if (sync_variant && (cnt_r == cyclic_msg_pkg::AXIS_LAST))
                    sync_echo_r <= last_sync_r;
            end
        end
    end

    // input image read port: response, handshake word, then status block
    assign stat_in_off = in_addr - cyclic_msg_pkg::IN_STAT_BASE;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            in_data_r <= 16'h0000;
        else if (!block_mode)
            in_data_r <= (sync_variant && (in_addr == 7'h00)) ? sync_echo_r : 16'h0000;
        else if (in_addr == cyclic_msg_pkg::IN_HS_IDX)
        begin
            in_data_r <= 16'h0000;
            in_data_r[cyclic_msg_pkg::RD_FLAG_BIT] <= rd_ack_r;
            in_data_r[cyclic_msg_pkg::WR_FLAG_BIT] <= wr_ack_r;
        end
        else if (in_addr < cyclic_msg_pkg::IN_HS_IDX)
            in_data_r <= resp_mem_r[in_addr[5:0]];
        else if (in_addr <= cyclic_msg_pkg::IN_LAST)
            in_data_r <= stat_mem_r[stat_in_off[4:0]];
        else
            in_data_r <= 16'h0000;
    end
endmodule : fieldbus_cyclic_message_port
`default_nettype wire

// >>> verification/reg_space_model.sv
// register space model answering the port's strobes
`timescale 1ns/1ns
`default_nettype none
module reg_space_model (
    input wire logic ref_clk,
    input wire logic reg_wr_en_r,
    input wire logic reg_rd_en_r,
    input wire logic [15:0] reg_addr_r,
    input wire logic [15:0] reg_wdata_r,
    output logic [15:0] reg_rdata
);
    logic [15:0] mem [256];
    initial
    begin
        foreach (mem[i]) mem[i] = 16'h0000;
        reg_rdata = 16'h0000;
    end
    // data only valid after a strobe; flips to expose late samples
    always @(posedge ref_clk)
    begin
        if (reg_wr_en_r) mem[reg_addr_r[7:0]] <= reg_wdata_r;
        reg_rdata <= reg_rd_en_r ? mem[reg_addr_r[7:0]] : ~reg_rdata;
    end
endmodule : reg_space_model
`default_nettype wire

// >>> verification/msg_port_assertions.sv
// assertions on the port's register strobes and axis pulses
`timescale 1ns/1ns
`default_nettype none
module msg_port_checker #(
    parameter logic [15:0] SPLINE_FIRST = 16'h4000,
    parameter logic [15:0] SPLINE_LAST = 16'h7fff
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reg_wr_en_r,
    input wire logic reg_rd_en_r,
    input wire logic [15:0] reg_addr_r,
    input wire logic axis_cmd_valid_r,
    input wire logic [2:0] axis_idx_r,
    input wire logic [15:0] axis_cmd_r,
    input wire logic wait_bit7_r,
    input wire logic wait_bit7_clr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [15:0] last_cmd [8];
    // last command issued per axis
    always_ff @(posedge ref_clk)
    begin
        if (rst) last_cmd <= '{default: 16'h0000};
        else if (axis_cmd_valid_r) last_cmd[axis_idx_r] <= axis_cmd_r;
    end
    a_quiet_after_reset: assert property ($past(rst) |-> !reg_wr_en_r && !reg_rd_en_r && !axis_cmd_valid_r)
        else $error("strobe right after reset");
    a_no_repeat_cmd: assert property (axis_cmd_valid_r |-> axis_cmd_r != last_cmd[axis_idx_r])
        else $error("repeated axis command issued");
    a_ro_write_drop: assert property (reg_wr_en_r |-> reg_addr_r >= cyclic_msg_pkg::RO_END)
        else $error("write strobe to read-only area");
    a_map_kept_inside: assert property ((reg_wr_en_r || reg_rd_en_r) |->
        !(reg_addr_r inside {[cyclic_msg_pkg::MAP_BASE:cyclic_msg_pkg::MAP_LAST]}))
        else $error("status map access left the block");
    a_wr_addr_step: assert property (reg_wr_en_r && $past(reg_wr_en_r) |-> reg_addr_r == $past(reg_addr_r) + 16'h0001)
        else $error("write addresses not ascending");
    a_rd_wr_apart: assert property (reg_wr_en_r |-> !reg_rd_en_r)
        else $error("read and write strobes together");
    a_spline_sets: assert property (reg_wr_en_r && reg_addr_r >= SPLINE_FIRST && reg_addr_r <= SPLINE_LAST
        |-> ##[0:2] wait_bit7_r)
        else $error("spline write left wait flag low");
    a_wait_only_clr: assert property ($fell(wait_bit7_r) |-> $past(wait_bit7_clr))
        else $error("wait flag fell without clear");
endmodule : msg_port_checker
bind fieldbus_cyclic_message_port msg_port_checker #(.SPLINE_FIRST(SPLINE_FIRST), .SPLINE_LAST(SPLINE_LAST)) chk (
    .ref_clk(ref_clk), .rst(rst), .reg_wr_en_r(reg_wr_en_r), .reg_rd_en_r(reg_rd_en_r), .reg_addr_r(reg_addr_r),
    .axis_cmd_valid_r(axis_cmd_valid_r), .axis_idx_r(axis_idx_r), .axis_cmd_r(axis_cmd_r),
    .wait_bit7_r(wait_bit7_r), .wait_bit7_clr(wait_bit7_clr));
`default_nettype wire

// >>> verification/fieldbus_cyclic_message_port_test.sv
// testbench for the cyclic message port
`timescale 1ns/1ns
`default_nettype none
module fieldbus_cyclic_message_port_test;
    logic ref_clk, rst, block_mode, sync_variant, out_we, wait_bit7_clr;
    logic reg_wr_en_r, reg_rd_en_r, axis_cmd_valid_r, wait_bit7_r;
    logic [5:0] out_addr;
    logic [6:0] in_addr;
    logic [2:0] axis_idx_r;
    logic [15:0] out_data, in_data_r, reg_addr_r, reg_wdata_r, reg_rdata, axis_cmd_r, axis_data_r, hs, v;
    logic [34:0] cap;
    int mismatches = 0, num_checks = 0, pulses = 0;
    fieldbus_cyclic_message_port #(.IDLE_REFRESH_CYC(20), .BUSY_REFRESH_CYC(60)) dut (.ref_clk(ref_clk), .rst(rst),
        .block_mode(block_mode), .sync_variant(sync_variant), .out_we(out_we), .out_addr(out_addr),
        .out_data(out_data), .in_addr(in_addr), .in_data_r(in_data_r), .reg_wr_en_r(reg_wr_en_r),
        .reg_rd_en_r(reg_rd_en_r), .reg_addr_r(reg_addr_r), .reg_wdata_r(reg_wdata_r), .reg_rdata(reg_rdata),
        .axis_cmd_valid_r(axis_cmd_valid_r), .axis_idx_r(axis_idx_r), .axis_cmd_r(axis_cmd_r),
        .axis_data_r(axis_data_r), .wait_bit7_r(wait_bit7_r), .wait_bit7_clr(wait_bit7_clr));
    reg_space_model regs (.ref_clk(ref_clk), .reg_wr_en_r(reg_wr_en_r), .reg_rd_en_r(reg_rd_en_r),
        .reg_addr_r(reg_addr_r), .reg_wdata_r(reg_wdata_r), .reg_rdata(reg_rdata));
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic ow(input logic [5:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        out_we <= 1'b1;
        out_addr <= a;
        out_data <= d;
        @(posedge ref_clk);
        out_we <= 1'b0;
    endtask : ow
    task automatic ir(input logic [6:0] a);
        @(posedge ref_clk);
        in_addr <= a;
        @(posedge ref_clk);
        @(negedge ref_clk);
        v = in_data_r;
    endtask : ir
    // toggle flags and wait until an ack moves
    task automatic req(input logic [15:0] m);
        hs = hs ^ m;
        v = hs ^ m;
        ow(6'h3f, hs);
        for (int i = 0; i < 300 && (v & 16'hc000) === (hs ^ m); i++) ir(7'h3f);
        chk("ack word", hs, v);
    endtask : req
    task automatic results;
        if (mismatches == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    // axis pulse monitor
    always @(posedge ref_clk)
    begin
        if (axis_cmd_valid_r) pulses <= pulses + 1;
        if (axis_cmd_valid_r) cap <= {axis_idx_r, axis_cmd_r, axis_data_r};
    end
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial
    begin
        #2000000;
        mismatches++;
        results();
    end
    initial
    begin
        {rst, block_mode, sync_variant, out_we, wait_bit7_clr} = 5'b11000;
        {out_addr, out_data, in_addr, hs} = '0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        ir(7'h3f);
        chk("ack reset", 16'h0000, v);
        ow(6'h00, 16'h1111);
        ow(6'h01, 16'h2222);
        ow(6'h3b, 16'h0120);
        ow(6'h3c, 16'h0002);
        req(16'h4000);
        chk("wr w1", 16'h2222, regs.mem[8'h21]);
        ow(6'h3d, 16'h0120);
        ow(6'h3e, 16'h0002);
        req(16'h8000);
        ir(7'h01);
        chk("rd w1", 16'h2222, v);
        req(16'h8000);
        ow(6'h00, 16'h3333);
        req(16'hc000);
        ir(7'h00);
        chk("joint rd", 16'h3333, v);
        ow(6'h3b, 16'h0010);
        ow(6'h3c, 16'h0001);
        req(16'h4000);
        chk("ro area", 16'h0000, regs.mem[8'h10]);
        ow(6'h3b, 16'h0a00);
        ow(6'h00, 16'h0120);
        req(16'h4000);
        ow(6'h3d, 16'h0a00);
        ow(6'h3e, 16'h0001);
        req(16'h8000);
        ir(7'h00);
        chk("map rd", 16'h0120, v);
        repeat (150) @(posedge ref_clk);
        ir(7'h40);
        chk("status w0", 16'h3333, v);
        ow(6'h3b, 16'h4000);
        req(16'h4000);
        chk("wait7 set", 16'h0001, {15'h0, wait_bit7_r});
        @(posedge ref_clk) wait_bit7_clr <= 1'b1;
        repeat (2) @(posedge ref_clk);
        wait_bit7_clr <= 1'b0;
        chk("clr7", 16'h0000, {15'h0, wait_bit7_r});
        // axis pair loaded before the mode switch
        ow(6'h01, 16'h0241);
        ow(6'h02, 16'h1234);
        ow(6'h00, 16'h0001);
        sync_variant <= 1'b1;
        block_mode <= 1'b0;
        repeat (60) @(posedge ref_clk);
        chk("pulses", 16'h0001, 16'(pulses));
        chk("axis0 cmd", 16'h0241, cap[31:16]);
        chk("axis0 data", 16'h1234, cap[15:0]);
        ir(7'h00);
        chk("sync echo", 16'h0001, v);
        ow(6'h00, 16'h0002);
        repeat (20) @(posedge ref_clk);
        chk("dup cmd", 16'h0001, 16'(pulses));
        ow(6'h01, 16'h0261);
        ow(6'h00, 16'h0003);
        repeat (20) @(posedge ref_clk);
        chk("case cmd", 16'h0002, 16'(pulses));
        results();
    end
endmodule : fieldbus_cyclic_message_port_test
`default_nettype wire
